// File: hw/bst_pkg.sv
// Purpose: Constants and types for the boundary-scan test port
// Assumes: Ten-bit instruction register, 32-bit identification and signature
// Notes:   Identification fields are arbitrary neutral values
package bst_pkg;
   localparam int IR_LEN  = 10;
   localparam int DR_LEN  = 32;
   localparam int BSR_LEN = 480;
   localparam int USR_LEN = 7;

   localparam logic [9:0] IR_CAPTURE   = 10'h001;
   localparam logic [9:0] IR_EXTEST    = 10'h000;
   localparam logic [9:0] IR_CFG_LOAD  = 10'h002;
   localparam logic [9:0] IR_CFG_START = 10'h003;
   localparam logic [9:0] IR_SAMPLE    = 10'h005;
   localparam logic [9:0] IR_IDCODE    = 10'h006;
   localparam logic [9:0] IR_USERCODE  = 10'h007;
   localparam logic [9:0] IR_BYPASS    = 10'h3FF;

   // Arbitrary identification values
   localparam logic [3:0]  ID_VERSION = 4'h1;
   localparam logic [15:0] ID_PART    = 16'h5A3C;
   localparam logic [10:0] ID_MFR     = 11'h2B5;
   localparam logic [31:0] ID_VALUE   = {ID_VERSION, ID_PART, ID_MFR, 1'b1};
   // Arbitrary maker-fixed part of the user signature
   localparam logic [24:0] USER_FIXED = 25'h155_AAAA;

   // Pull-up level of an open test input
   localparam logic [2:0] SYNC_PULLUP = 3'h7;

   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
   } bst_tap_t;
endpackage

// File: hw/bst_bsr.sv
// Purpose: Boundary register: capture, shift and update stages
// Assumes: Strobes are one-cycle pulses on clk
// Notes:   Update stage clears to zero at reset
`timescale 1ns/1ps
module bst_bsr #(
   parameter int LEN = bst_pkg::BSR_LEN
) (
   input  wire logic           clk,
   input  wire logic           nrst,
   input  wire logic           cap,
   input  wire logic           sh,
   input  wire logic           upd,
   input  wire logic           si,
   input  wire logic [LEN-1:0] pin_in,
   output logic                so,
   output logic      [LEN-1:0] upd_q
);
   typedef struct packed {
      logic [LEN-1:0] sr;
      logic [LEN-1:0] upd;
   } bst_bsr_t;

   bst_bsr_t s_q;
   bst_bsr_t s_d;

   always_comb begin
      s_d = s_q;
      if (cap) begin
         s_d.sr = pin_in;
      end else if (sh) begin
         s_d.sr = {si, s_q.sr[LEN-1:1]};
      end
      if (upd) begin
         s_d.upd = s_q.sr;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign so    = s_q.sr[0];
   assign upd_q = s_q.upd;
endmodule // bst_bsr

// File: hw/bst_tap.sv
// Purpose: Boundary-scan test access port with configuration instructions
// Assumes: TCK far slower than clk; sampled through three flip-flops
// Notes:   Update actions happen on the rising TCK edge leaving Update
`timescale 1ns/1ps
module bst_tap #(
   parameter int                      BSR_LEN   = bst_pkg::BSR_LEN,
   parameter logic [bst_pkg::USR_LEN-1:0] USER_BITS = 7'h00
) (
   input  wire logic               clk,
   input  wire logic               nrst,
   input  wire logic               tck,
   input  wire logic               tms,
   input  wire logic               tdi,
   input  wire logic               pwr_ok,
   input  wire logic               cfg_busy,
   input  wire logic [BSR_LEN-1:0] pin_in,
   input  wire logic [BSR_LEN-1:0] core_out,
   output logic                    tdo,
   output logic                    tdo_oe_n,
   output logic                    pins_hiz,
   output logic      [BSR_LEN-1:0] pin_out,
   output logic                    cfg_bit,
   output logic                    cfg_stb,
   output logic                    cfg_start
);
   typedef struct packed {
      logic [2:0]         tck_s;
      logic [2:0]         tms_s;
      logic [2:0]         tdi_s;
      logic               tck_lvl;
      logic               tms_lvl;
      logic               tdi_lvl;
      bst_pkg::bst_tap_t  st;
      logic [9:0]         ir_sr;
      logic [9:0]         ir_q;
      logic [31:0]        dr_sr;
      logic               tdo;
      logic               tdo_oe_n;
      logic               hiz;
      logic [BSR_LEN-1:0] pout;
      logic               cfg_bit;
      logic               cfg_stb;
      logic               cfg_start;
   } bst_tap_state_t;

   bst_tap_state_t s_q;
   bst_tap_state_t s_d;

   logic rise;
   logic fall;
   logic tms_v;
   logic tdi_v;
   logic bsr_sel;
   logic dr32_sel;
   logic ext_act;
   logic bsr_so;
   logic [BSR_LEN-1:0] bsr_upd;

   ////////////////////////////////////////////////////////////////////////////
   // Controller next state
   function automatic bst_pkg::bst_tap_t tap_next(bst_pkg::bst_tap_t st, logic m);
      unique case (st)
         bst_pkg::TLR:    tap_next = m ? bst_pkg::TLR    : bst_pkg::RTI;
         bst_pkg::RTI:    tap_next = m ? bst_pkg::SEL_DR : bst_pkg::RTI;
         bst_pkg::SEL_DR: tap_next = m ? bst_pkg::SEL_IR : bst_pkg::CAP_DR;
         bst_pkg::CAP_DR: tap_next = m ? bst_pkg::EX1_DR : bst_pkg::SH_DR;
         bst_pkg::SH_DR:  tap_next = m ? bst_pkg::EX1_DR : bst_pkg::SH_DR;
         bst_pkg::EX1_DR: tap_next = m ? bst_pkg::UPD_DR : bst_pkg::PA_DR;
         bst_pkg::PA_DR:  tap_next = m ? bst_pkg::EX2_DR : bst_pkg::PA_DR;
         bst_pkg::EX2_DR: tap_next = m ? bst_pkg::UPD_DR : bst_pkg::SH_DR;
         bst_pkg::UPD_DR: tap_next = m ? bst_pkg::SEL_DR : bst_pkg::RTI;
         bst_pkg::SEL_IR: tap_next = m ? bst_pkg::TLR    : bst_pkg::CAP_IR;
         bst_pkg::CAP_IR: tap_next = m ? bst_pkg::EX1_IR : bst_pkg::SH_IR;
         bst_pkg::SH_IR:  tap_next = m ? bst_pkg::EX1_IR : bst_pkg::SH_IR;
         bst_pkg::EX1_IR: tap_next = m ? bst_pkg::UPD_IR : bst_pkg::PA_IR;
         bst_pkg::PA_IR:  tap_next = m ? bst_pkg::EX2_IR : bst_pkg::PA_IR;
         bst_pkg::EX2_IR: tap_next = m ? bst_pkg::UPD_IR : bst_pkg::SH_IR;
         bst_pkg::UPD_IR: tap_next = m ? bst_pkg::SEL_DR : bst_pkg::RTI;
      endcase
   endfunction

   function automatic logic [31:0] dr_capture(logic [9:0] ir);
      if (ir == bst_pkg::IR_IDCODE) begin
         dr_capture = bst_pkg::ID_VALUE;
      end else if (ir == bst_pkg::IR_USERCODE) begin
         dr_capture = {bst_pkg::USER_FIXED, USER_BITS};
      end else begin
         dr_capture = 32'h0000_0000;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Edge detection and path selection
   assign rise  = (s_q.tck_s[1] == s_q.tck_s[2]) && s_q.tck_s[2] && !s_q.tck_lvl;
   assign fall  = (s_q.tck_s[1] == s_q.tck_s[2]) && !s_q.tck_s[2] && s_q.tck_lvl;
   assign tms_v = s_q.tms_lvl;
   assign tdi_v = s_q.tdi_lvl;
   assign bsr_sel  = (s_q.ir_q == bst_pkg::IR_EXTEST || s_q.ir_q == bst_pkg::IR_SAMPLE)
                     && !cfg_busy;
   assign dr32_sel = s_q.ir_q == bst_pkg::IR_IDCODE || s_q.ir_q == bst_pkg::IR_USERCODE;
   assign ext_act  = s_q.ir_q == bst_pkg::IR_EXTEST && !cfg_busy;

   bst_bsr #(
      .LEN (BSR_LEN)
   ) u_bsr (
      .clk    (clk),
      .nrst   (nrst),
      .cap    (rise && s_q.st == bst_pkg::CAP_DR && bsr_sel),
      .sh     (rise && s_q.st == bst_pkg::SH_DR && bsr_sel),
      .upd    (rise && s_q.st == bst_pkg::UPD_DR && bsr_sel),
      .si     (tdi_v),
      .pin_in (pin_in),
      .so     (bsr_so),
      .upd_q  (bsr_upd)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      s_d           = s_q;
      s_d.tck_s     = {s_q.tck_s[1:0], tck};
      s_d.tms_s     = {s_q.tms_s[1:0], tms};
      s_d.tdi_s     = {s_q.tdi_s[1:0], tdi};
      s_d.cfg_stb   = 1'b0;
      s_d.cfg_start = 1'b0;
      if (s_q.tck_s[1] == s_q.tck_s[2]) begin
         s_d.tck_lvl = s_q.tck_s[2];
      end
      // Mode and data levels settle once stages two and three agree
      if (s_q.tms_s[1] == s_q.tms_s[2]) begin
         s_d.tms_lvl = s_q.tms_s[2];
      end
      if (s_q.tdi_s[1] == s_q.tdi_s[2]) begin
         s_d.tdi_lvl = s_q.tdi_s[2];
      end
      if (rise) begin
         s_d.st = tap_next(s_q.st, tms_v);
         unique case (s_q.st)
            bst_pkg::CAP_IR: s_d.ir_sr = bst_pkg::IR_CAPTURE;
            bst_pkg::SH_IR:  s_d.ir_sr = {tdi_v, s_q.ir_sr[9:1]};
            bst_pkg::UPD_IR: s_d.ir_q  = s_q.ir_sr;
            bst_pkg::CAP_DR: s_d.dr_sr = dr_capture(s_q.ir_q);
            bst_pkg::SH_DR: begin
               if (dr32_sel) begin
                  s_d.dr_sr = {tdi_v, s_q.dr_sr[31:1]};
               end else begin
                  s_d.dr_sr = {s_q.dr_sr[31:1], tdi_v};
               end
               if (s_q.ir_q == bst_pkg::IR_CFG_LOAD) begin
                  s_d.cfg_bit = tdi_v;
                  s_d.cfg_stb = 1'b1;
               end
            end
            bst_pkg::UPD_DR: s_d.cfg_start = s_q.ir_q == bst_pkg::IR_CFG_START;
            default: ;
         endcase
      end
      if (s_d.st == bst_pkg::TLR) begin
         s_d.ir_q = bst_pkg::IR_IDCODE;
      end
      if (fall) begin
         s_d.tdo_oe_n = !(s_q.st == bst_pkg::SH_DR || s_q.st == bst_pkg::SH_IR);
         if (s_q.st == bst_pkg::SH_IR) begin
            s_d.tdo = s_q.ir_sr[0];
         end else if (bsr_sel) begin
            s_d.tdo = bsr_so;
         end else begin
            s_d.tdo = s_q.dr_sr[0];
         end
      end
      s_d.hiz  = !pwr_ok;
      s_d.pout = ext_act ? bsr_upd : core_out;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_q          <= '0;
         s_q.tms_s    <= bst_pkg::SYNC_PULLUP;
         s_q.tdi_s    <= bst_pkg::SYNC_PULLUP;
         s_q.tms_lvl  <= 1'b1;
         s_q.tdi_lvl  <= 1'b1;
         s_q.ir_q     <= bst_pkg::IR_IDCODE;
         s_q.tdo_oe_n <= 1'b1;
         s_q.hiz      <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign tdo       = s_q.tdo;
   assign tdo_oe_n  = s_q.tdo_oe_n;
   assign pins_hiz  = s_q.hiz;
   assign pin_out   = s_q.pout;
   assign cfg_bit   = s_q.cfg_bit;
   assign cfg_stb   = s_q.cfg_stb;
   assign cfg_start = s_q.cfg_start;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   AST_PWR_HIZ: assert property (!pwr_ok |=> pins_hiz)
      else $error("pins driven before power good");
   AST_CFG_NOEXT: assert property (cfg_busy |=> pin_out == $past(core_out))
      else $error("boundary pattern driven during configuration");
   AST_SAMPLE_NORMAL: assert property (s_q.ir_q == bst_pkg::IR_SAMPLE |=> pin_out == $past(core_out))
      else $error("sample disturbed pins");
   AST_EXTEST_DRIVE: assert property (ext_act |=> pin_out == $past(bsr_upd))
      else $error("extest pattern not on pins");
   AST_BYPASS_BIT: assert property (rise && s_q.st == bst_pkg::SH_DR && s_q.ir_q == bst_pkg::IR_BYPASS
      |=> s_q.dr_sr[0] == $past(tdi_v))
      else $error("bypass bit not loaded from tdi");
   AST_USER_CAP: assert property (rise && s_q.st == bst_pkg::CAP_DR && s_q.ir_q == bst_pkg::IR_USERCODE
      |=> s_q.dr_sr == {bst_pkg::USER_FIXED, USER_BITS})
      else $error("user signature not captured");
   AST_ID_CAP: assert property (rise && s_q.st == bst_pkg::CAP_DR && s_q.ir_q == bst_pkg::IR_IDCODE
      |=> s_q.dr_sr[0] && s_q.dr_sr[31:28] == bst_pkg::ID_VERSION)
      else $error("identification not captured");
   AST_CFG_STB: assert property (rise && s_q.st == bst_pkg::SH_DR && s_q.ir_q == bst_pkg::IR_CFG_LOAD
      |=> cfg_stb && cfg_bit == $past(tdi_v) ##1 !cfg_stb)
      else $error("configuration bit strobe wrong");
   AST_IR_CAP: assert property (rise && s_q.st == bst_pkg::CAP_IR |=> s_q.ir_sr == bst_pkg::IR_CAPTURE)
      else $error("instruction capture value wrong");
   AST_TDO_FALL: assert property ($changed(tdo) |-> $past(fall))
      else $error("tdo changed off a falling edge");
   AST_TLR_ID: assert property (s_q.st == bst_pkg::TLR |-> s_q.ir_q == bst_pkg::IR_IDCODE)
      else $error("reset state lost identification");
   AST_PULLUP: assert property ($rose(nrst) |-> tms_v && tdi_v)
      else $error("test inputs not pulled high at reset");

   COV_ID_SHIFT: cover property (s_q.st == bst_pkg::SH_DR && s_q.ir_q == bst_pkg::IR_IDCODE);
   COV_EXTEST: cover property (ext_act && rise && s_q.st == bst_pkg::UPD_DR);
   COV_CFG: cover property (cfg_start);
endmodule // bst_tap

// File: testbench/bst_ctl_model.sv
// Purpose: Test controller model driving the four-wire link
// Assumes: Link clock 400 ns, low and still between frames
// Notes:   Released mode and data lines sit at the pull-up level
`timescale 1ns/1ps
module bst_ctl_model (
   input  wire logic clk,
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////
   // One link cycle: set lines, sample output, rise, fall
   task automatic step(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      repeat (4) @(negedge clk);
      q = tdo;
      tck = 1'b1;
      repeat (4) @(negedge clk);
      tck = 1'b0;
   endtask
   task automatic reset_tap();
      logic q;
      repeat (5) step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
   endtask
   // From idle: shift n bits least significant first, back to idle
   task automatic scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
      logic q;
      dout = '0;
      step(1'b1, 1'b1, q);
      if (ir) step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
      step(1'b0, 1'b1, q);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
      tms = 1'b1;
      tdi = 1'b1;
      @(negedge clk);
   endtask
endmodule // bst_ctl_model

// File: testbench/testbench.sv
// Purpose: Self-checking bench of the boundary-scan test port
// Assumes: Short boundary register of 8 cells
// Notes:   Inputs change at the falling clock edge
`timescale 1ns/1ps
module testbench;
   localparam int         BL = 8;
   localparam logic [6:0] UB = 7'h5A;
   logic          clk, nrst, tck, tms, tdi, tdo, tdo_oe_n, pins_hiz;
   logic          pwr_ok, cfg_busy, cfg_bit, cfg_stb, cfg_start;
   logic [BL-1:0] pin_in, core_out, pin_out;
   logic [63:0]   dout;
   logic [7:0]    stb_bits;
   int            n_fail, cmp_count, stb_cnt, start_cnt;

   bst_tap #(.BSR_LEN(BL), .USER_BITS(UB)) u_dut (
      .clk(clk), .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi), .pwr_ok(pwr_ok), .cfg_busy(cfg_busy),
      .pin_in(pin_in), .core_out(core_out), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .pins_hiz(pins_hiz),
      .pin_out(pin_out), .cfg_bit(cfg_bit), .cfg_stb(cfg_stb), .cfg_start(cfg_start)
   );
   bst_ctl_model u_ctl (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(negedge clk) begin
      if (cfg_stb === 1'b1) begin
         stb_cnt++;
         stb_bits = {cfg_bit, stb_bits[7:1]};
      end
      if (cfg_start === 1'b1) start_cnt++;
   end
   task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic close_out();
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic load_ir(input logic [9:0] code);
      u_ctl.scan(1'b1, 10, {54'h0, code}, dout);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_power();
      @(negedge clk);
      check("pins_hiz", 64'h1, pins_hiz);
      check("tdo_oe_n", 64'h1, tdo_oe_n);
      pwr_ok = 1'b1;
      repeat (2) @(negedge clk);
      check("pins_hiz", 64'h0, pins_hiz);
      check("pin_out", core_out, pin_out);
   endtask
   task automatic t_id();
      u_ctl.reset_tap();
      u_ctl.scan(1'b0, 32, 64'h0, dout);
      check("idcode", bst_pkg::ID_VALUE, dout);
      check("id_lsb", 64'h1, dout[0]);
      load_ir(bst_pkg::IR_USERCODE);
      check("ir_capture", 64'h001, dout);
      u_ctl.scan(1'b0, 32, 64'h0, dout);
      check("usercode", {bst_pkg::USER_FIXED, UB}, dout);
   endtask
   task automatic t_bypass();
      logic [9:0] codes [2];
      codes[0] = bst_pkg::IR_BYPASS;
      codes[1] = 10'h155;
      foreach (codes[k]) begin
         load_ir(codes[k]);
         u_ctl.scan(1'b0, 9, 64'h0A5, dout);
         check("bypass", 64'h14A, dout);
      end
   endtask
   task automatic t_boundary();
      @(negedge clk);
      pin_in = 8'h3C;
      load_ir(bst_pkg::IR_SAMPLE);
      u_ctl.scan(1'b0, BL, 64'h96, dout);
      check("sample_cap", 64'h3C, dout);
      check("sample_pins", core_out, pin_out);
      load_ir(bst_pkg::IR_EXTEST);
      repeat (2) @(negedge clk);
      check("preload_drive", 64'h96, pin_out);
      pin_in = 8'h5A;
      u_ctl.scan(1'b0, BL, 64'h21, dout);
      check("extest_cap", 64'h5A, dout);
      check("extest_drive", 64'h21, pin_out);
      cfg_busy = 1'b1;
      repeat (2) @(negedge clk);
      check("busy_pins", core_out, pin_out);
      u_ctl.scan(1'b0, 9, 64'h0A5, dout);
      check("busy_path", 64'h14A, dout);
      cfg_busy = 1'b0;
      u_ctl.reset_tap();
      check("reset_pins", core_out, pin_out);
      check("oe_idle", 64'h1, tdo_oe_n);
   endtask
   task automatic t_cfg();
      load_ir(bst_pkg::IR_CFG_LOAD);
      stb_cnt = 0;
      u_ctl.scan(1'b0, 8, 64'hB4, dout);
      check("cfg_count", 64'd8, stb_cnt);
      check("cfg_bits", 64'hB4, stb_bits);
      load_ir(bst_pkg::IR_CFG_START);
      start_cnt = 0;
      u_ctl.scan(1'b0, 1, 64'h0, dout);
      check("cfg_start", 64'd1, start_cnt);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (100000) @(posedge clk);
      n_fail++;
      close_out();
   end
   initial begin
      nrst = 1'b0;
      pwr_ok = 1'b0;
      cfg_busy = 1'b0;
      pin_in = '0;
      core_out = 8'hC3;
      stb_bits = '0;
      n_fail = 0;
      cmp_count = 0;
      stb_cnt = 0;
      start_cnt = 0;
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      t_power();
      t_id();
      t_bypass();
      t_boundary();
      t_cfg();
      close_out();
   end
endmodule // testbench
